/* logic/tac_defs.vh */
// Constants for the type A timer control block.
`ifndef TAC_DEFS_VH
`define TAC_DEFS_VH
`define TAC_CTRL_ADDR      12'h000
`define TAC_COUNT_ADDR     12'h004
`define TAC_ADDR_W         12
`define TAC_RUN_POS        15
`define TAC_IDLE_STOP_POS  13
`define TAC_GATE_POS       6
`define TAC_PS_HI          5
`define TAC_PS_LO          4
`define TAC_SYNC_POS       2
`define TAC_CSRC_POS       1
`define TAC_CTRL_WMASK     16'ha076
`define TAC_CTRL_RESET     16'h0000
`define TAC_PS_1           2'h0
`define TAC_PS_8           2'h1
`define TAC_PS_64          2'h2
`define TAC_PS_256         2'h3
`define TAC_DIV_8          8'h07
`define TAC_DIV_64         8'h3f
`define TAC_DIV_256        8'hff
`define TAC_HTRANS_NONSEQ  2'h2
`define TAC_HSIZE_WORD     3'h2
`endif

/* logic/tac_timer.v */
// Type A timer control register, prescaler and count enable with an AHB-Lite slave.
// Behaviour
// - Idle-stop set: counting halts while the device is idle.
// - Idle-stop clear: counting continues during idle.
// - Prescale bits 5:4 divide by 1, 8, 64 or 256.
// - External source with sync set: pin is synchronised before counting.
// - External source with sync clear: pin counted without synchronising.
// - Internal source: sync bit ignored, reads 0, internal clock counts.
// - Bit 1 selects external pin (1) or internal clock (0).
// - Bits 14, 12-7, 3 and 0 read zero, writes ignored.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "tac_defs.vh"
module tac_timer
(
  input  wire        clk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        idle_mode,
  input  wire        external_count_clock_pin,
  input  wire        gate_pin,
  output reg         count_tick,
  output reg  [15:0] count_value
);

  reg  [15:0] timer_control;
  reg  [15:0] next_timer_control;
  reg         wr_pend;
  reg  [11:0] addr_q;
  reg  [31:0] next_hrdata;
  reg         ext_meta;
  reg         ext_sync;
  reg         ext_sync_d;
  reg         ext_raw_d;
  reg  [7:0]  pre_cnt;
  reg  [7:0]  next_pre_cnt;
  reg         next_count_tick;
  reg  [15:0] next_count_value;

  wire        run       = timer_control[`TAC_RUN_POS];
  wire        idle_stop = timer_control[`TAC_IDLE_STOP_POS];
  wire        csrc      = timer_control[`TAC_CSRC_POS];
  wire        sync_sel  = timer_control[`TAC_SYNC_POS];
  wire        gate_en   = timer_control[`TAC_GATE_POS];
  wire [1:0]  ps        = timer_control[`TAC_PS_HI:`TAC_PS_LO];
  wire        take      = hsel & hready & (htrans == `TAC_HTRANS_NONSEQ);

  // Prescale terminal value for the selected ratio.
  function [7:0] div_top;
    input [1:0] code;
    begin
      case (code)
        `TAC_PS_8:   div_top = `TAC_DIV_8;
        `TAC_PS_64:  div_top = `TAC_DIV_64;
        `TAC_PS_256: div_top = `TAC_DIV_256;
        default:     div_top = 8'h00;
      endcase
    end
  endfunction

  // Readback view: sync bit hides while the internal clock is selected.
  function [15:0] ctrl_view;
    input [15:0] r;
    begin
      ctrl_view = r;
      if (!r[`TAC_CSRC_POS])
        ctrl_view[`TAC_SYNC_POS] = 1'b0;
    end
  endfunction

  wire idle_hold = idle_mode & idle_stop;
  wire gate_ok   = ~gate_en | csrc | gate_pin;
  wire counting  = run & ~idle_hold & gate_ok;

  wire ext_edge_sync  = ext_sync & ~ext_sync_d;
  wire ext_edge_async = external_count_clock_pin & ~ext_raw_d;
  wire src_edge = csrc ? (sync_sel ? ext_edge_sync : ext_edge_async) : 1'b1;

  wire pre_done = (pre_cnt >= div_top(ps));

  always @(posedge clk)
  begin
    if (reset)
    begin
      ext_meta   <= 1'b0;
      ext_sync   <= 1'b0;
      ext_sync_d <= 1'b0;
    end
    else
    begin
      ext_meta   <= external_count_clock_pin;
      ext_sync   <= ext_meta;
      ext_sync_d <= ext_sync;
    end
  end

  // unsynchronised edge history
  // The direct path trades metastability margin for two cycles less latency.
  always @(posedge clk)
  begin
    if (reset)
    begin
      ext_raw_d <= 1'b0;
    end
    else
    begin
      ext_raw_d <= external_count_clock_pin;
    end
  end

  // Next prescaler, tick and count values.
  always @*
  begin
    next_pre_cnt     = pre_cnt;
    next_count_tick  = 1'b0;
    next_count_value = count_value;
    if (counting && src_edge)
    begin
      if (pre_done)
      begin
        next_pre_cnt     = 8'h00;
        next_count_tick  = 1'b1;
        next_count_value = count_value + 16'h0001;
      end
      else
      begin
        next_pre_cnt = pre_cnt + 8'h01;
      end
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      pre_cnt     <= 8'h00;
      count_tick  <= 1'b0;
      count_value <= 16'h0000;
    end
    else
    begin
      pre_cnt     <= next_pre_cnt;
      count_tick  <= next_count_tick;
      count_value <= next_count_value;
    end
  end

  // Next control value from a pending word write.
  always @*
  begin
    next_timer_control = timer_control;
    if (wr_pend && (addr_q == `TAC_CTRL_ADDR))
    begin
      next_timer_control = hwdata[15:0] & `TAC_CTRL_WMASK;
    end
  end

  // Read data for the address phase being taken.
  always @*
  begin
    next_hrdata = hrdata;
    if (take && !hwrite)
    begin
      case (haddr[`TAC_ADDR_W-1:0])
        `TAC_CTRL_ADDR:  next_hrdata = {16'h0000, ctrl_view(timer_control)};
        `TAC_COUNT_ADDR: next_hrdata = {16'h0000, count_value};
        default:         next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Zero wait states and an OKAY response on every transfer.
  always @(posedge clk)
  begin
    if (reset)
    begin
      timer_control <= `TAC_CTRL_RESET;
      wr_pend       <= 1'b0;
      addr_q        <= 12'h000;
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end
    else
    begin
      wr_pend       <= take & hwrite & (hsize == `TAC_HSIZE_WORD);
      timer_control <= next_timer_control;
      hrdata        <= next_hrdata;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      if (take)
      begin
        addr_q <= haddr[`TAC_ADDR_W-1:0];
      end
    end
  end

endmodule

/* tb/tac_timer_bench.sv */
// Bench for the type A timer control block.
`timescale 1ns/10ps
module tac_timer_bench;
reg clk=0,reset=1,hsel=0,hwrite=0,idle_mode=0,gate_pin=0;
reg [1:0] htrans=0;
reg [31:0] haddr=0,hwdata=0,q,cyc=0,tbl[11];
wire [31:0] hrdata;
wire [15:0] count_value;
wire [2:0] hsize=3'h2;
wire hreadyout,hresp,count_tick,hready=hreadyout,external_count_clock_pin=cyc[3];
int errors=0,checks_done=0,ticks=0,t0;
tac_timer i_tac_timer(.*);
initial forever #12.5 clk=~clk;
always @(posedge clk)
begin
  cyc<=cyc+1;
  ticks<=ticks+count_tick;
end
task chk(input [31:0] g,e);
  checks_done++;
  if(g!==e) begin errors++; $display("unexpected at %0t: got %h not %h",$time,g,e); end
endtask
task bus(input w,input [31:0] a,d);
  @(posedge clk); hsel<=1; htrans<=2'h2; hwrite<=w; haddr<=a;
  do @(posedge clk); while(hreadyout!==1);
  hsel<=0; htrans<=0; hwdata<=d;
  do @(posedge clk); while(hreadyout!==1);
  q=hrdata;
  chk(hresp,0);
endtask
task close_out;
  $display("checks %0d errors %0d",checks_done,errors);
  if(errors==0&&checks_done>0) $display("Finished cleanly");
  else $display("Finished with errors");
  $finish;
endtask
initial begin #500000; errors++; close_out; end
initial
begin
  tbl='{32'h80100020,32'h80200004,32'h80300001,32'ha0004000,32'h80004100,32'h0,32'h80400000,32'h80408100,
    32'h80420010,32'h80060010,32'h80020010};
  repeat(8) @(posedge clk); reset<=0;
  bus(0,0,0); chk(q,0);
  bus(1,0,-1); bus(0,0,0); chk(q,32'ha076);
  bus(1,0,32'h8004); bus(0,12,0); chk(q,0);
  bus(0,0,0); chk(q,32'h8000);
  foreach(tbl[i])
  begin
    @(posedge clk);
    gate_pin<=tbl[i][15]; idle_mode<=tbl[i][14]; bus(1,0,tbl[i][31:16]);
    repeat(6) @(posedge clk); @(negedge clk); t0=ticks; repeat(256) @(negedge clk);
    chk(ticks-t0,tbl[i][8:0]);
  end
  bus(1,0,0); repeat(4) @(posedge clk);
  bus(0,4,0); chk(q,ticks&32'hffff);
  chk(count_value,ticks&32'hffff);
  close_out;
end
endmodule

/* tb/tac_timer_props.sv */
// Checker for the type A timer control block.
`timescale 1ns/10ps
module tac_timer_props(input wire clk,reset,hsel,hwrite,hready,hreadyout,hresp,idle_mode,external_count_clock_pin,
  gate_pin,count_tick,input wire [31:0] haddr,hwdata,hrdata,input wire [1:0] htrans,input wire [2:0] hsize,
  input wire [15:0] count_value);
reg [15:0] ctl;
reg wp,rp;
wire tk=hsel&hready&htrans==2'h2&haddr==0;
always @(posedge clk)
begin
  wp<=!reset&tk&hwrite&hsize==3'h2;
  rp<=!reset&tk&!hwrite;
  ctl<=reset?16'h0:wp?hwdata[15:0]&16'ha076:ctl;
end
default clocking @(posedge clk); endclocking
default disable iff (reset);
a_read_ctl: assert property (rp|->hrdata=={16'h0,ctl&(ctl[1]?16'ha076:16'ha072)}) else $error("bad read");
a_stop_quiet: assert property ((!ctl[15])[*3]|->!count_tick) else $error("tick stopped");
a_idle_halt: assert property ((ctl[13]&idle_mode)[*3]|->!count_tick) else $error("tick idle");
a_idle_run: assert property ((ctl==16'h8000)[*3]|->count_tick) else $error("no tick");
a_div_eight: assert property (ctl==16'h8010&&$past(ctl,9)==16'h8010&&count_tick
  |->$past(count_tick,8)&&!$past(count_tick)) else $error("bad divide");
a_gate_low: assert property ((ctl==16'h8040&!gate_pin)[*3]|->!count_tick) else $error("tick gated");
a_pin_quiet: assert property ((ctl[1]&!external_count_clock_pin)[*6]|->!count_tick) else $error("tick no pin");
a_sync_edge: assert property (ctl==16'h8006&&$rose(external_count_clock_pin)|->##[1:5] count_tick) else $error("lost");
cover property (rp);
cover property (ctl[1]&count_tick);
cover property (ctl[4]&count_tick);
endmodule
bind tac_timer tac_timer_props i_props(.*);
